// [hdl/pot_front_end.v]
// Serial slave front end and register core of a 64-tap potentiometer.
// Assumes host pins are asynchronous to clk; sck is far slower than clk.
`include "pot_front_end_consts.vh"

module pot_front_end #(
    parameter STORE_CYCLES = `STORE_CYCLES,
    parameter [`WIPER_W-1:0] SLOT_INIT = `SLOT_RESET_VALUE
)(
    input wire clk,
    input wire nrst,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire wp_n,
    output reg so,
    output reg so_oe_n,
    output reg [`WIPER_W-1:0] wiper_position,
    output reg [`TAP_COUNT-1:0] tap_select,
    output reg store_in_progress_flag,
    output reg standby,
    output reg active
);

    localparam integer STORE_LAST_INT = STORE_CYCLES - 1;
    localparam [`STORE_CNT_W-1:0] STORE_LAST = STORE_LAST_INT[`STORE_CNT_W-1:0];

    // Store sequencer states
    localparam [1:0] NV_IDLE = 2'b00;
    localparam [1:0] NV_PEND = 2'b01;
    localparam [1:0] NV_BUSY = 2'b10;

    function [`TAP_COUNT-1:0] tap_decode;
        input [`WIPER_W-1:0] pos;
        integer k;
        begin
            for (k = 0; k < `TAP_COUNT; k = k + 1)
                tap_decode[k] = (pos == k[`WIPER_W-1:0]);
        end
    endfunction

    // Stored slots are not touched by reset: they model nonvolatile cells
    reg [`WIPER_W-1:0] stored_setting_registers [0:`SLOT_COUNT-1];
    integer i;
    initial
    begin
        for (i = 0; i < `SLOT_COUNT; i = i + 1)
            stored_setting_registers[i] = SLOT_INIT;
    end

    reg [`PIN_COUNT-1:0] sync1_reg;
    reg [`PIN_COUNT-1:0] sync2_reg;
    reg [`PIN_COUNT-1:0] sync3_reg;
    reg [`PIN_COUNT-1:0] pin_reg;
    wire [`PIN_COUNT-1:0] pin_next;
    wire [`PIN_COUNT-1:0] agree;

    reg [`WIPER_W-1:0] wiper_position_register;
    reg recall_reg;
    reg armed_reg;
    reg [`BIT_CNT_W-1:0] bit_cnt_reg;
    reg [`BYTE_W-1:0] cmd_reg;
    reg [`BYTE_W-1:0] rx_reg;
    reg [`BYTE_W-1:0] tx_reg;
    reg read_phase_reg;
    reg [1:0] nv_state_reg;
    reg [1:0] nv_state_next;
    reg [`SLOT_IDX_W-1:0] pend_slot_reg;
    reg [`WIPER_W-1:0] pend_data_reg;
    reg [`STORE_CNT_W-1:0] store_cnt_reg;

    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g = g + 1)
        begin : pin_filter
            // A change counts only once the second and third stages agree;
            // a one-stage glitch never reaches the frame logic
            assign agree[g] = ~(sync2_reg[g] ^ sync3_reg[g]);
            assign pin_next[g] = agree[g] ? sync3_reg[g] : pin_reg[g];
        end
    endgenerate

    wire cs_fall = pin_reg[`PIN_CS] & ~pin_next[`PIN_CS];
    wire cs_rise = ~pin_reg[`PIN_CS] & pin_next[`PIN_CS];
    wire sck_rise = ~pin_reg[`PIN_SCK] & pin_next[`PIN_SCK];
    wire sck_fall = pin_reg[`PIN_SCK] & ~pin_next[`PIN_SCK];
    wire selected = armed_reg & ~pin_reg[`PIN_CS];

    wire [`BYTE_W-1:0] rx_shift = {rx_reg[`BYTE_W-2:0], pin_next[`PIN_SI]};
    wire [2:0] op = cmd_reg[`OP_MSB:`OP_LSB];
    wire [2:0] op_now = rx_shift[`OP_MSB:`OP_LSB];
    wire [`SLOT_IDX_W-1:0] slot_now = rx_shift[`SLOT_MSB:`SLOT_LSB];
    wire [`SLOT_IDX_W-1:0] slot = cmd_reg[`SLOT_MSB:`SLOT_LSB];
    wire nv_allowed = pin_reg[`PIN_WP] & (nv_state_reg == NV_IDLE);
    wire store_done = (nv_state_reg == NV_BUSY) & (store_cnt_reg == STORE_LAST);
    wire cmd_end = selected & sck_rise & (bit_cnt_reg == `CMD_DONE_BITS - 5'h01);
    wire data_end = selected & sck_rise & (bit_cnt_reg == `FRAME_DONE_BITS - 5'h01);
    // Both slot-changing commands funnel into one request for the sequencer
    wire nv_req = nv_allowed & ((cmd_end & (op_now == `OP_WIPER_TO_SLOT)) |
        (data_end & (op == `OP_WR_SLOT)));

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            sync1_reg <= {`PIN_COUNT{1'b0}};
            sync2_reg <= {`PIN_COUNT{1'b0}};
            sync3_reg <= {`PIN_COUNT{1'b0}};
            pin_reg <= {`PIN_COUNT{1'b0}};
        end
        else
        begin
            sync1_reg <= {wp_n, si, sck, cs_n};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg <= pin_next;
        end
    end

    // Nonvolatile slot update lands at the end of the store time
    always @(posedge clk)
    begin
        if (nrst && store_done)
            stored_setting_registers[pend_slot_reg] <= pend_data_reg;
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            wiper_position_register <= {`WIPER_W{1'b0}};
            recall_reg <= 1'b1;
            armed_reg <= 1'b0;
            bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
            cmd_reg <= {`BYTE_W{1'b0}};
            rx_reg <= {`BYTE_W{1'b0}};
            tx_reg <= {`BYTE_W{1'b0}};
            read_phase_reg <= 1'b0;
            pend_slot_reg <= {`SLOT_IDX_W{1'b0}};
            pend_data_reg <= {`WIPER_W{1'b0}};
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end
        else
        begin
            recall_reg <= 1'b0;
            if (recall_reg)
                wiper_position_register <= stored_setting_registers[0];
            // Reset leaves the select level low, so a select held low through
            // power-up must first go high before a frame can open
            if (cs_fall)
                armed_reg <= 1'b1;
            if (pin_reg[`PIN_CS] || !armed_reg)
            begin
                bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
                read_phase_reg <= 1'b0;
                so_oe_n <= 1'b1;
            end
            else if (sck_rise)
            begin
                rx_reg <= rx_shift;
                if (bit_cnt_reg != `FRAME_DONE_BITS)
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if (bit_cnt_reg == `CMD_DONE_BITS - 5'h01)
                begin
                    cmd_reg <= rx_shift;
                    read_phase_reg <= 1'b0;
                    case (op_now)
                        `OP_RD_WIPER:
                        begin
                            tx_reg <= {2'b00, wiper_position_register};
                            read_phase_reg <= 1'b1;
                        end
                        `OP_RD_SLOT:
                        begin
                            tx_reg <= {2'b00, stored_setting_registers[slot_now]};
                            read_phase_reg <= 1'b1;
                        end
                        `OP_RD_STATUS:
                        begin
                            tx_reg <= {7'h00, store_in_progress_flag};
                            read_phase_reg <= 1'b1;
                        end
                        `OP_SLOT_TO_WIPER:
                            wiper_position_register <= stored_setting_registers[slot_now];
                        `OP_WIPER_TO_SLOT:
                        begin
                            if (nv_allowed)
                            begin
                                pend_slot_reg <= slot_now;
                                pend_data_reg <= wiper_position_register;
                            end
                        end
                        default:
                            tx_reg <= {`BYTE_W{1'b0}};
                    endcase
                end
                else if (bit_cnt_reg == `FRAME_DONE_BITS - 5'h01)
                begin
                    case (op)
                        `OP_WR_WIPER:
                            wiper_position_register <= rx_shift[`WIPER_W-1:0];
                        `OP_WR_SLOT:
                        begin
                            if (nv_allowed)
                            begin
                                pend_slot_reg <= slot;
                                pend_data_reg <= rx_shift[`WIPER_W-1:0];
                            end
                        end
                        default:
                            cmd_reg <= cmd_reg;
                    endcase
                end
            end
            else if (sck_fall && read_phase_reg)
            begin
                // Bits beyond the data byte shift out as zero
                so <= tx_reg[`BYTE_W-1];
                tx_reg <= {tx_reg[`BYTE_W-2:0], 1'b0};
                so_oe_n <= 1'b0;
            end
        end
    end

    // Only a complete write sequence arms the store; a frame cut short before its last
    // command bit (wiper to slot) or last data bit (slot write) never reaches the pending state. Deselecting never stops a running store.
    always @*
    begin
        nv_state_next = nv_state_reg;
        case (nv_state_reg)
            NV_IDLE:
            begin
                // Select rising on the edge of the last bit still starts it
                if (nv_req && cs_rise)
                    nv_state_next = NV_BUSY;
                else if (nv_req)
                    nv_state_next = NV_PEND;
            end
            NV_PEND:
            begin
                if (cs_rise)
                    nv_state_next = NV_BUSY;
            end
            NV_BUSY:
            begin
                if (store_done)
                    nv_state_next = NV_IDLE;
            end
            default:
                nv_state_next = NV_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            nv_state_reg <= NV_IDLE;
            store_cnt_reg <= {`STORE_CNT_W{1'b0}};
            store_in_progress_flag <= 1'b0;
        end
        else
        begin
            nv_state_reg <= nv_state_next;
            // The counter runs only while busy, so every store starts from zero
            if (nv_state_reg == NV_BUSY)
                store_cnt_reg <= store_cnt_reg + {{(`STORE_CNT_W-1){1'b0}}, 1'b1};
            else
                store_cnt_reg <= {`STORE_CNT_W{1'b0}};
            store_in_progress_flag <= (nv_state_next == NV_BUSY);
        end
    end

    // Outputs are registered one cycle behind the core state
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            wiper_position <= {`WIPER_W{1'b0}};
            tap_select <= {`TAP_COUNT{1'b0}};
            standby <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            wiper_position <= wiper_position_register;
            tap_select <= tap_decode(wiper_position_register);
            standby <= ~selected & (nv_state_reg == NV_IDLE);
            active <= selected;
        end
    end

endmodule

// [hdl/pot_front_end_consts.vh]
// Constants for the serial potentiometer front end.
// Assumes a single 40 MHz system clock and a sampled serial host link.
`ifndef POT_FRONT_END_CONSTS_VH
`define POT_FRONT_END_CONSTS_VH

// Register geometry
`define WIPER_W 6
`define TAP_COUNT 64
`define SLOT_COUNT 4
`define SLOT_IDX_W 2
`define SLOT_RESET_VALUE 6'h00

// Frame layout: one command byte, then one data byte
`define BYTE_W 8
`define BIT_CNT_W 5
`define CMD_DONE_BITS 5'h08
`define FRAME_DONE_BITS 5'h10

// Command byte: opcode in bits 7:5, slot index in bits 1:0
`define OP_MSB 7
`define OP_LSB 5
`define OP_RD_WIPER 3'h0
`define OP_WR_WIPER 3'h1
`define OP_RD_SLOT 3'h2
`define OP_WR_SLOT 3'h3
`define OP_RD_STATUS 3'h4
`define OP_SLOT_TO_WIPER 3'h5
`define OP_WIPER_TO_SLOT 3'h6
`define SLOT_MSB 1
`define SLOT_LSB 0

// Synchronised pin vector positions
`define PIN_CS 0
`define PIN_SCK 1
`define PIN_SI 2
`define PIN_WP 3
`define PIN_COUNT 4

// Nonvolatile store time
`define CLK_FREQ_MHZ 40
`define STORE_TIME_US 10000
`define STORE_CYCLES (`STORE_TIME_US * `CLK_FREQ_MHZ)
`define STORE_CNT_W 19

`endif

// [tb/pot_front_end_checker.sv]
// Assertions on the ports of the potentiometer front end.
// Assumes one clock, clk, and the synchronous active-low reset nrst.
module pot_front_end_checker #(
    parameter int STORE_CYCLES = 20
) (
    input wire clk,
    input wire nrst,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire wp_n,
    input wire so,
    input wire so_oe_n,
    input wire [5:0] wiper_position,
    input wire [63:0] tap_select,
    input wire store_in_progress_flag,
    input wire standby,
    input wire active
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Counts the store length so a wrong time constant shows up
    always_ff @(posedge clk)
        cnt <= (!nrst || !store_in_progress_flag) ? 0 : cnt + 1;
    property p_tap; $past(nrst, 3) |-> $onehot(tap_select) && tap_select[wiper_position]; endproperty
    a_tap: assert property (p_tap) else $error("tap select not one-hot on wiper");
    property p_hiz; cs_n [*6] |-> so_oe_n; endproperty
    a_hiz: assert property (p_hiz) else $error("serial output driven while deselected");
    property p_sb; (cs_n && !store_in_progress_flag) [*8] |-> standby; endproperty
    a_sb: assert property (p_sb) else $error("no standby while idle");
    property p_busy; store_in_progress_flag |-> !standby; endproperty
    a_busy: assert property (p_busy) else $error("standby during store");
    property p_act; (!cs_n) [*6] |-> active && !standby; endproperty
    a_act: assert property (p_act) else $error("not active while selected");
    property p_start; $rose(store_in_progress_flag) |-> cs_n && $past(cs_n, 2); endproperty
    a_start: assert property (p_start) else $error("store began before select rise");
    property p_wp; $rose(store_in_progress_flag) |-> wp_n; endproperty
    a_wp: assert property (p_wp) else $error("store began while protected");
    property p_so; !so_oe_n && $changed(so) |-> !$past(sck, 2) && ($past(sck, 5) ||
        $past(sck, 6) || $past(sck, 7)); endproperty
    a_so: assert property (p_so) else $error("serial output moved off a falling clock");
    property p_len; $fell(store_in_progress_flag) |-> $past(cnt) >= STORE_CYCLES - 2 &&
        $past(cnt) <= STORE_CYCLES + 1; endproperty
    a_len: assert property (p_len) else $error("store length wrong");
    cover property (!so_oe_n);
    cover property ($rose(store_in_progress_flag));
    cover property (!cs_n && active);
endmodule

bind pot_front_end pot_front_end_checker #(.STORE_CYCLES(STORE_CYCLES)) chk (.clk(clk),
    .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
    .wiper_position(wiper_position), .tap_select(tap_select), .standby(standby),
    .store_in_progress_flag(store_in_progress_flag), .active(active));

// [tb/pot_front_end_tb_top.sv]
// Self-checking bench: random wiper and slot traffic with corner values.
// Assumes the host model and the bound checker; store time is shortened.
`include "pot_front_end_consts.vh"
module pot_front_end_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 600;
    localparam logic [5:0] INIT = 6'h2A;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wp_n = 1'b1;
    wire cs_n, sck, si, so, so_oe_n, store_in_progress_flag, standby, active;
    wire [5:0] wiper_position;
    wire [63:0] tap_select;
    wire so_line;
    int err_total = 0;
    int comparisons = 0;
    logic [5:0] slot_exp [4];
    logic [7:0] rd, v;
    always #12.5 clk = ~clk;
    // A released line reads back inverted, so a read outside the drive window fails
    assign so_line = so_oe_n ? ~so : so;
    pot_front_end #(.STORE_CYCLES(SC), .SLOT_INIT(INIT)) dut (.clk(clk), .nrst(nrst),
        .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
        .wiper_position(wiper_position), .tap_select(tap_select), .standby(standby),
        .store_in_progress_flag(store_in_progress_flag), .active(active));
    spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
    task automatic check(input string n, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        err_total++;
        finish_test();
    end
    initial
    begin
        void'($urandom(32'h29E8F20A));
        for (int i = 0; i < 4; i++) slot_exp[i] = INIT;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(negedge clk);
        check("wiper", INIT, wiper_position);
        check("standby", 1'b1, standby);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            // All-ones first: upper data bits must not leak into the wiper
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            host.frame({`OP_WR_WIPER, 5'h00}, v, rd);
            @(negedge clk);
            check("taps", 64'h1 << v[5:0], tap_select);
            check("oe_n", 1'b1, so_oe_n);
            check("active", 1'b0, active);
            check("standby", 1'b1, standby);
            host.frame({`OP_RD_WIPER, 5'h00}, 8'h00, rd);
            check("rd_wiper", {2'b00, v[5:0]}, rd);
        end
        $display("test wiper done");
        for (int s = 0; s < 6; s++)
        begin
            v = 8'($urandom);
            @(posedge clk) wp_n <= (s != 2 && s != 5);
            host.frame({`OP_WR_SLOT, 3'b000, 2'(s)}, v, rd);
            @(negedge clk);
            check("flag", wp_n, store_in_progress_flag);
            host.frame({`OP_RD_STATUS, 5'h00}, 8'h00, rd);
            check("status", {7'h00, wp_n}, rd);
            for (int n = 0; n < SC && store_in_progress_flag !== 1'b0; n++) @(negedge clk);
            check("flag", 1'b0, store_in_progress_flag);
            if (wp_n) slot_exp[s % 4] = v[5:0];
            host.frame({`OP_RD_SLOT, 3'b000, 2'(s)}, 8'h00, rd);
            check("rd_slot", {2'b00, slot_exp[s % 4]}, rd);
        end
        $display("test slots done");
        for (int s = 0; s < 4; s++)
        begin
            host.frame({`OP_SLOT_TO_WIPER, 3'b000, 2'(s)}, 8'h00, rd);
            @(negedge clk);
            check("wiper", slot_exp[s], wiper_position);
        end
        for (int s = 0; s < 2; s++)
        begin
            v = 8'($urandom);
            @(posedge clk) wp_n <= (s == 0);
            host.frame({`OP_WR_WIPER, 5'h00}, v, rd);
            host.frame({`OP_WIPER_TO_SLOT, 3'b000, 2'(s + 2)}, 8'h00, rd);
            @(negedge clk);
            check("flag", wp_n, store_in_progress_flag);
            for (int n = 0; n < SC && store_in_progress_flag !== 1'b0; n++) @(negedge clk);
            check("flag", 1'b0, store_in_progress_flag);
            if (wp_n) slot_exp[s + 2] = v[5:0];
            host.frame({`OP_RD_SLOT, 3'b000, 2'(s + 2)}, 8'h00, rd);
            check("rd_slot", {2'b00, slot_exp[s + 2]}, rd);
        end
        $display("test wiper store done");
        @(posedge clk) nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(negedge clk);
        check("wiper", slot_exp[0], wiper_position);
        host.frame({`OP_RD_SLOT, 5'h03}, 8'h00, rd);
        check("rd_slot", {2'b00, slot_exp[3]}, rd);
        $display("test transfer and reset done");
        finish_test();
    end
endmodule

// [tb/spi_host_model.sv]
// Serial host model: one frame is a command byte and a data byte.
// Assumes clk is the bench clock; sck stands low outside frames.
module spi_host_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, dat};
        rd = 8'h00;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge clk) si <= sh[i];
            repeat (HALF) @(negedge clk);
            // Sampled off the edge so the answer is settled
            if (i < 8) rd[i] = so;
            @(posedge clk) sck <= 1'b1;
            repeat (HALF) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        cs_n <= 1'b1;
        repeat (2 * HALF) @(posedge clk);
    endtask
endmodule
